// ===== src/cpwd_config_port_watchdog.sv
// Countdown supervisor behind an indexed configuration port pair.
// Functional notes
// [RULE1] Enabled with a nonzero count, the counter decrements toward zero.
// [RULE2] When the count reaches zero unreloaded, a system reset is asserted.
// [RULE3] Host must reload or disable before expiry to avoid the reset.
// [RULE4] Writing 0x87 twice to index port 0x2E unlocks register access.
// [RULE5] Index to 0x2E, value to 0x2F; device 08 at index 07 selects us.
// [RULE6] Index 0x30: 01 activates, 00 deactivates and stops any reset; a pulse already firing still runs its full 16 cycles.
// [RULE7] Index 0xF0: 00 gives one-second units, 08 one-minute units.
// [RULE8] Index 0xF1 holds the count in the selected units.
// [RULE9] Host picks timeout above task runtime, reloads or disables after.
// [RULE10] Writing the count while enabled restarts from the new value.
`timescale 1ns/100ps
`default_nettype none
module cpwd_config_port_watchdog
#(
  parameter int SEC_CYCLES = cpwd_pkg::CPWD_SEC_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic sys_reset,
  output logic cfg_unlocked,
  output logic [7:0] remain_count
);
  import cpwd_pkg::*;

  // ----------------------------------------------------------------
  // Configuration port decode
  // ----------------------------------------------------------------
  logic key_seen_reg, key_seen_next;
  logic unlocked_reg, unlocked_next;
  logic [7:0] index_reg, index_next;
  logic [7:0] ldev_reg, ldev_next;
  logic [7:0] act_reg, act_next;
  logic [7:0] unit_reg, unit_next;
  logic [7:0] count_reg, count_next;
  // Live remaining count, declared here because reads of 0xf1 return it.
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic load_pulse;
  logic sel_supv;
  logic wr_index, wr_data, rd_data;

  assign wr_index = io_wr && (io_addr == CPWD_INDEX_PORT);
  assign wr_data = io_wr && (io_addr == CPWD_DATA_PORT) && unlocked_reg;
  assign rd_data = io_rd && (io_addr == CPWD_DATA_PORT) && unlocked_reg;
  assign sel_supv = (ldev_reg == CPWD_LDEV_SUPV);

  // Register writes and reads; supervisor registers only when selected.
  always_comb
  begin
    key_seen_next = key_seen_reg;
    unlocked_next = unlocked_reg;
    index_next = index_reg;
    ldev_next = ldev_reg;
    act_next = act_reg;
    unit_next = unit_reg;
    count_next = count_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    load_pulse = 1'b0;
    if (wr_index)
    begin
      if (!unlocked_reg)
      begin
        // Any other byte between the two keys restarts the sequence.
        if (io_wdata == CPWD_UNLOCK_KEY)
        begin
          key_seen_next = !key_seen_reg; // [RULE4]
          unlocked_next = key_seen_reg; // [RULE4]
        end
        else
        begin
          key_seen_next = 1'b0;
        end
      end
      else
      begin
        index_next = io_wdata; // [RULE5]
      end
    end
    if (wr_data)
    begin
      if (index_reg == CPWD_IDX_LDEV)
      begin
        ldev_next = io_wdata; // [RULE5]
      end
      else if (sel_supv)
      begin
        unique case (index_reg)
          CPWD_IDX_ACT: act_next = io_wdata; // [RULE6]
          CPWD_IDX_UNIT: unit_next = io_wdata; // [RULE7]
          CPWD_IDX_COUNT:
          begin
            count_next = io_wdata; // [RULE8]
            load_pulse = 1'b1; // [RULE10]
          end
          default: ;
        endcase
      end
    end
    if (rd_data)
    begin
      rvalid_next = 1'b1;
      rdata_next = 8'h00;
      if (index_reg == CPWD_IDX_LDEV)
      begin
        rdata_next = ldev_reg;
      end
      else if (sel_supv)
      begin
        unique case (index_reg)
          CPWD_IDX_ACT: rdata_next = act_reg;
          CPWD_IDX_UNIT: rdata_next = unit_reg;
          CPWD_IDX_COUNT: rdata_next = cnt_reg;
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      key_seen_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      index_reg <= CPWD_RST_BYTE;
      ldev_reg <= CPWD_RST_BYTE;
      act_reg <= CPWD_ACT_OFF;
      unit_reg <= CPWD_UNIT_SEC;
      count_reg <= CPWD_RST_BYTE;
      rdata_reg <= CPWD_RST_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      key_seen_reg <= key_seen_next;
      unlocked_reg <= unlocked_next;
      index_reg <= index_next;
      ldev_reg <= ldev_next;
      act_reg <= act_next;
      unit_reg <= unit_next;
      count_reg <= count_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  cpwd_state_t state_reg, state_next;
  logic [31:0] tick_reg, tick_next;
  logic [5:0] sec_reg, sec_next;
  logic [7:0] pulse_reg, pulse_next;
  logic rst_reg, rst_next;
  logic enabled;
  logic unit_done;

  // Only the exact code 01 activates; every other value keeps it off.
  assign enabled = (act_reg == CPWD_ACT_ON);

  // A unit ends at the last cycle of a second, or of the 60th second.
  always_comb
  begin
    unit_done = (tick_reg == SEC_CYCLES - 1) &&
      ((unit_reg != CPWD_UNIT_MIN) ||
       (sec_reg == 6'(CPWD_MIN_SECONDS - 1))); // [RULE7]
  end

  // Units other than 00 and 08 run as seconds, the safer short choice.
  always_comb
  begin
    state_next = state_reg;
    tick_next = tick_reg;
    sec_next = sec_reg;
    cnt_next = cnt_reg;
    pulse_next = pulse_reg;
    rst_next = 1'b0;
    unique case (state_reg)
      CPWD_IDLE:
      begin
        tick_next = 32'h0;
        sec_next = 6'h0;
        cnt_next = count_reg;
        if (enabled && count_reg != 8'h00)
        begin
          state_next = CPWD_RUN; // [RULE1]
        end
      end
      CPWD_RUN:
      begin
        if (!enabled)
        begin
          state_next = CPWD_IDLE; // [RULE6]
        end
        else if (load_pulse)
        begin
          tick_next = 32'h0;
          sec_next = 6'h0;
          cnt_next = io_wdata; // [RULE10]
          if (io_wdata == 8'h00)
          begin
            state_next = CPWD_IDLE;
          end
        end
        else if (unit_done)
        begin
          tick_next = 32'h0;
          sec_next = 6'h0;
          cnt_next = cnt_reg - 8'h01; // [RULE1]
          if (cnt_reg == 8'h01)
          begin
            state_next = CPWD_FIRE; // [RULE2]
            pulse_next = CPWD_RST_PULSE;
          end
        end
        else
        begin
          tick_next = tick_reg + 32'h1;
          if (tick_reg == SEC_CYCLES - 1)
          begin
            tick_next = 32'h0;
            sec_next = sec_reg + 6'h1;
          end
        end
      end
      CPWD_FIRE:
      begin
        rst_next = 1'b1; // [RULE2]
        pulse_next = pulse_reg - 8'h01;
        if (pulse_reg == 8'h01)
        begin
          // The last count still drives the pulse, so it is full width.
          // Activation stays set; a reset pin would clear it in a system.
          state_next = CPWD_IDLE;
        end
      end
      default: state_next = CPWD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= CPWD_IDLE;
      tick_reg <= 32'h0;
      sec_reg <= 6'h0;
      cnt_reg <= CPWD_RST_BYTE;
      pulse_reg <= CPWD_RST_BYTE;
      rst_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      sec_reg <= sec_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
      rst_reg <= rst_next;
    end
  end

  // Outputs straight from flip-flops.
  assign io_rdata = rdata_reg;
  assign io_rvalid = rvalid_reg;
  assign sys_reset = rst_reg;
  assign cfg_unlocked = unlocked_reg;
  assign remain_count = cnt_reg;
endmodule
`default_nettype wire

// ===== src/cpwd_pkg.sv
// Package with port addresses, register indices, codes and timing counts.
package cpwd_pkg;
  // I/O port addresses of the index and data ports.
  localparam logic [15:0] CPWD_INDEX_PORT = 16'h002e;
  localparam logic [15:0] CPWD_DATA_PORT = 16'h002f;
  // Byte that must be written twice to the index port to unlock.
  localparam logic [7:0] CPWD_UNLOCK_KEY = 8'h87;
  // Register indices.
  localparam logic [7:0] CPWD_IDX_LDEV = 8'h07;
  localparam logic [7:0] CPWD_IDX_ACT = 8'h30;
  localparam logic [7:0] CPWD_IDX_UNIT = 8'hf0;
  localparam logic [7:0] CPWD_IDX_COUNT = 8'hf1;
  // Logical device number of the countdown supervisor.
  localparam logic [7:0] CPWD_LDEV_SUPV = 8'h08;
  // Activate and unit codes.
  localparam logic [7:0] CPWD_ACT_ON = 8'h01;
  localparam logic [7:0] CPWD_ACT_OFF = 8'h00;
  localparam logic [7:0] CPWD_UNIT_SEC = 8'h00;
  localparam logic [7:0] CPWD_UNIT_MIN = 8'h08;
  // Reset values.
  localparam logic [7:0] CPWD_RST_BYTE = 8'h00;
  // Timing: clock rate, one second in cycles, seconds per minute.
  localparam int CPWD_CLK_HZ = 10_000_000;
  localparam int CPWD_SEC_S = 1;
  localparam int CPWD_SEC_CYCLES = CPWD_SEC_S * CPWD_CLK_HZ;
  localparam int CPWD_MIN_SECONDS = 60;
  // Width of the system reset pulse in clock cycles.
  localparam logic [7:0] CPWD_RST_PULSE = 8'h10;
  // Main states of the countdown.
  typedef enum logic [2:0]
  {
    CPWD_IDLE = 3'b001,
    CPWD_RUN = 3'b010,
    CPWD_FIRE = 3'b100
  } cpwd_state_t;
endpackage

// ===== verif/cpwd_checker.sv
// Port checker for the countdown supervisor.
`timescale 1ns/100ps
`default_nettype none
module cpwd_checker
#(
  parameter int SEC_CYCLES = cpwd_pkg::CPWD_SEC_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic sys_reset,
  input wire logic cfg_unlocked,
  input wire logic [7:0] remain_count
);
  import cpwd_pkg::*;
  logic [7:0] idx_reg;
  logic [7:0] idx_next;
  logic key_wr;
  logic off_wr;
  logic key_prev_reg;
  logic key_prev_next;
  // Decoded key writes and writes that switch the countdown off.
  assign key_wr = io_wr && io_addr == CPWD_INDEX_PORT
    && io_wdata == CPWD_UNLOCK_KEY;
  assign off_wr = io_wr && io_addr == CPWD_DATA_PORT && cfg_unlocked
    && idx_reg == CPWD_IDX_ACT && io_wdata == CPWD_ACT_OFF;
  // Last index byte, so data writes can be decoded.
  always_comb
  begin
    idx_next = idx_reg;
    if (io_wr && io_addr == CPWD_INDEX_PORT && cfg_unlocked)
      idx_next = io_wdata;
  end
  // A first key stays noted while locked until another index byte comes.
  always_comb
  begin
    key_prev_next = key_prev_reg;
    if (io_wr && io_addr == CPWD_INDEX_PORT && !cfg_unlocked)
      key_prev_next = (io_wdata == CPWD_UNLOCK_KEY);
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idx_reg <= 8'h00;
      key_prev_reg <= 1'b0;
    end
    else
    begin
      idx_reg <= idx_next;
      key_prev_reg <= key_prev_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rvalid_cause_a: assert property (io_rvalid |-> $past(io_rd))
    else $error("read data without a read");
  locked_read_a: assert property (io_rd && !cfg_unlocked
    |=> !io_rvalid) else $error("read answered while locked");
  unlock_keys_a: assert property ($rose(cfg_unlocked) |->
    $past(key_wr) && $past(key_prev_reg))
    else $error("unlocked without two keys");
  unlock_hold_a: assert property (cfg_unlocked |=> cfg_unlocked)
    else $error("configuration relocked");
  fire_zero_a: assert property ($rose(sys_reset)
    |-> remain_count == 8'h00) else $error("reset fired with count left");
  pulse_len_a: assert property ($fell(sys_reset)
    |-> $past(sys_reset, 16) && !$past(sys_reset, 17))
    else $error("reset pulse length wrong");
  count_step_a: assert property (remain_count != $past(remain_count)
    && $past(remain_count) != 8'h00 && !$past(io_wr) && !$past(io_wr, 2)
    |-> remain_count == $past(remain_count) - 8'h01)
    else $error("count moved by other than one");
  act_off_a: assert property (off_wr
    |-> ##2 (!$rose(sys_reset))[*8])
    else $error("reset fired after switch off");
endmodule
bind cpwd_config_port_watchdog cpwd_checker #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
  .clk(clk), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .sys_reset(sys_reset),
  .cfg_unlocked(cfg_unlocked), .remain_count(remain_count));
`default_nettype wire

// ===== verif/cpwd_host.sv
// Host model issuing port cycles on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module cpwd_host
(
  input wire logic clk,
  input wire logic io_rvalid,
  input wire logic [7:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  import cpwd_pkg::*;
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // One write; data is scrambled once released so stale values never help.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  // Index byte, then the value through the data port.
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(CPWD_INDEX_PORT, i);
    wr(CPWD_DATA_PORT, d);
  endtask
  // One read; the answer is the registered pulse after the read edge.
  task automatic rd(input logic [7:0] i, output logic v, output logic [7:0] d);
    wr(CPWD_INDEX_PORT, i);
    @(negedge clk);
    io_addr = CPWD_DATA_PORT;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rvalid;
    d = io_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking testbench for the countdown supervisor.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cpwd_pkg::*;
  localparam int SEC = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic io_wr, io_rd, io_rvalid, sys_reset, cfg_unlocked, v;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, remain_count, d;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  always #50 clk = ~clk;
  cpwd_config_port_watchdog #(.SEC_CYCLES(SEC)) i_dut (.clk(clk),
    .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .sys_reset(sys_reset), .cfg_unlocked(cfg_unlocked),
    .remain_count(remain_count));
  cpwd_host i_host (.clk(clk), .io_rvalid(io_rvalid), .io_rdata(io_rdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for the system reset; a timeout ends the run.
  task automatic fire(input int lim);
    n = 0;
    while (sys_reset !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lim)
    begin
      check(8'h00, 8'h01);
      results();
    end
  endtask
  // System reset must stay low for the given number of cycles.
  task automatic quiet(input int c);
    repeat (c)
    begin
      @(negedge clk);
      if (sys_reset !== 1'b0)
        check({7'h00, sys_reset}, 8'h00);
    end
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    i_host.rd(CPWD_IDX_ACT, v, d);
    check({7'h00, v}, 8'h00);
    i_host.wr(CPWD_INDEX_PORT, CPWD_UNLOCK_KEY);
    check({7'h00, cfg_unlocked}, 8'h00);
    i_host.wr(CPWD_INDEX_PORT, CPWD_UNLOCK_KEY);
    check({7'h00, cfg_unlocked}, 8'h01);
    // Three one-second units, then the reset pulse.
    i_host.reg_wr(CPWD_IDX_LDEV, CPWD_LDEV_SUPV);
    i_host.reg_wr(CPWD_IDX_UNIT, CPWD_UNIT_SEC);
    i_host.reg_wr(CPWD_IDX_COUNT, 8'h03);
    i_host.reg_wr(CPWD_IDX_ACT, CPWD_ACT_ON);
    fire(60);
    check(8'(n >= 3 * SEC - 2 && n <= 3 * SEC + 3), 8'h01);
    check(remain_count, 8'h00);
    n = 0;
    while (sys_reset === 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'h10);
    // A pulse that never ends is a hang, so the run is closed here.
    if (n >= 40)
      results();
    // Reloads inside the period hold the reset off.
    repeat (3)
    begin
      i_host.reg_wr(CPWD_IDX_COUNT, 8'h05);
      quiet(4 * SEC);
    end
    i_host.reg_wr(CPWD_IDX_COUNT, 8'h05);
    i_host.rd(CPWD_IDX_COUNT, v, d);
    check({7'h00, v}, 8'h01);
    check(d, 8'h05);
    i_host.reg_wr(CPWD_IDX_ACT, CPWD_ACT_OFF);
    quiet(12 * SEC);
    i_host.rd(CPWD_IDX_ACT, v, d);
    check(d, CPWD_ACT_OFF);
    // One minute unit: nothing for 58 seconds, reset within four more.
    i_host.reg_wr(CPWD_IDX_UNIT, CPWD_UNIT_MIN);
    i_host.reg_wr(CPWD_IDX_COUNT, 8'h01);
    i_host.reg_wr(CPWD_IDX_ACT, CPWD_ACT_ON);
    quiet(58 * SEC);
    fire(4 * SEC);
    check({7'h00, sys_reset}, 8'h01);
    // Another logical device hides the minute unit; reads give zero.
    i_host.reg_wr(CPWD_IDX_LDEV, 8'h01);
    i_host.rd(CPWD_IDX_UNIT, v, d);
    check({7'h00, v}, 8'h01);
    check(d, 8'h00);
    results();
  end
endmodule
`default_nettype wire
